// ==== ssx_pkg.sv ====
// Package of constants plus the machine-cycle timer for the pop/exchange executor
package ssx_pkg;
   // Opcodes
   localparam logic [7:0] OP_PREFIX_X = 8'hdd;
   localparam logic [7:0] OP_PREFIX_Y = 8'hfd;
   localparam logic [7:0] OP_POP_IDX = 8'he1;
   localparam logic [7:0] OP_SWAP_STACK = 8'he3;
   localparam logic [7:0] OP_SWAP_TGT_PTR = 8'heb;
   localparam logic [7:0] OP_SWAP_ACC = 8'h08;
   localparam logic [7:0] OP_BANK_SWITCH = 8'hd9;
   localparam logic [7:0] POP_MASK = 8'hcf;
   localparam logic [7:0] POP_PATTERN = 8'hc1;
   // Position of pair_select_field
   localparam int PAIR_FIELD_HI = 5;
   localparam int PAIR_FIELD_LO = 4;
   // pair_select_field codes
   localparam logic [1:0] PAIR_COUNTER = 2'h0;
   localparam logic [1:0] PAIR_TARGET = 2'h1;
   localparam logic [1:0] PAIR_POINTER = 2'h2;
   localparam logic [1:0] PAIR_ACCUM = 2'h3;
   // Clock states per machine cycle, one clock per state
   localparam int T_WIDTH = 3;
   localparam logic [T_WIDTH-1:0] T_FETCH = 3'h4;
   localparam logic [T_WIDTH-1:0] T_POP_RD = 3'h3;
   localparam logic [T_WIDTH-1:0] T_XCHG_RD_LO = 3'h3;
   localparam logic [T_WIDTH-1:0] T_XCHG_RD_HI = 3'h4;
   localparam logic [T_WIDTH-1:0] T_XCHG_WR_HI = 3'h3;
   localparam logic [T_WIDTH-1:0] T_XCHG_WR_LO = 3'h5;
   localparam logic [T_WIDTH-1:0] T_LAST = 3'h1;
   localparam logic [T_WIDTH-1:0] T_ONE = 3'h1;
   localparam logic [T_WIDTH-1:0] T_ZERO = 3'h0;
   // Reset values and address step
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] ADDR_STEP = 16'h0001;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // Sequencer states
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_FETCH = 6'h02,
      ST_RD_LO = 6'h04,
      ST_RD_HI = 6'h08,
      ST_WR_HI = 6'h10,
      ST_WR_LO = 6'h20
   } ssx_state_t;
endpackage

`timescale 1ns/1ps
module ssx_mcycle_timer
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Control
   input wire logic start_i,
   input wire logic [ssx_pkg::T_WIDTH-1:0] len_i,
   // Status
   output logic last_o
);
   logic [ssx_pkg::T_WIDTH-1:0] remain;

   assign last_o = (remain == ssx_pkg::T_LAST);

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         remain <= ssx_pkg::T_ZERO;
      else if (start_i)
         remain <= len_i;
      else if (remain != ssx_pkg::T_ZERO)
         remain <= remain - ssx_pkg::T_ONE;
   end
endmodule

// ==== ssx_exec.sv ====
// Stack-pop and register/stack exchange executor with its register file
`timescale 1ns/1ps

// Function
// - Opcode 11pp0001 pops into pair pp: counter 00, target 01, pointer 10, accum/flag 11.
// - A pair pop reads the low byte at the stack top, steps up, reads the high byte, steps up.
// - Prefix DD then E1 pops low, then high byte into index_reg_x, stack pointer two up.
// - Prefix FD then E1 pops into index_reg_y in the same order, incrementing after each read.
// - The 16-bit stack pointer is the memory address of every pop read and of the exchange's low-byte read.
// - Opcode EB swaps target and pointer pairs in one 4-state machine cycle, flags untouched.
// - Opcode 08 swaps the accum/flag pair with its alternate in one 4-state machine cycle.
// - Opcode D9 swaps counter, target and pointer pairs with their alternates in 4 states.
// - Opcode E3 swaps the pointer pair's low byte with the stack top, high byte one above.
// - The pointer-pair stack exchange takes five machine cycles of 4, 3, 4, 3 and 5 states.
// - Prefix DD then E3 swaps index_reg_x with the stack top in 23 states.
// - Stack exchanges leave the stack pointer unchanged.
// - Prefix FD then E3 swaps index_reg_y with the stack top in 23 states, stack pointer kept.
module ssx_exec
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Instruction fetch path
   input wire logic fetch_valid_i,
   input wire logic [7:0] fetch_byte_i,
   output logic fetch_ready_o,
   // External memory
   input wire logic [7:0] mem_rdata_i,
   output logic mem_rd_o,
   output logic mem_wr_o,
   output logic [15:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   // Completion
   output logic done_o,
   output logic illegal_o,
   // Register file
   output logic [15:0] counter_pair_o,
   output logic [15:0] target_pair_o,
   output logic [15:0] pointer_pair_o,
   output logic [15:0] accum_flag_pair_o,
   output logic [15:0] alt_counter_pair_o,
   output logic [15:0] alt_target_pair_o,
   output logic [15:0] alt_pointer_pair_o,
   output logic [15:0] alternate_accum_flag_pair_o,
   output logic [15:0] index_reg_x_o,
   output logic [15:0] index_reg_y_o,
   output logic [15:0] stack_pointer_o
);
   function automatic logic [15:0] inc16(input logic [15:0] v);
      inc16 = 16'(v + ssx_pkg::ADDR_STEP); // Carry dropped on purpose: wraps
   endfunction

   ssx_pkg::ssx_state_t state;
   ssx_pkg::ssx_state_t next_state;
   logic [7:0] op;
   logic pre_x;
   logic pre_y;
   logic [7:0] tmp_lo;
   logic [7:0] tmp_hi;
   logic t_last;
   logic t_start;
   logic [ssx_pkg::T_WIDTH-1:0] t_len;
   logic next_rd;
   logic next_wr;
   logic [15:0] next_addr;
   logic [7:0] next_wdata;
   logic [15:0] next_stack_ptr;
   logic next_done;
   logic next_illegal;
   logic wr_en;
   logic [15:0] wr_val;
   logic [1:0] wr_code;
   logic swap_tp;
   logic swap_acc;
   logic swap_bank;
   logic ld_lo;
   logic ld_hi;

   // Decode of the held opcode
   wire op_prefixed = pre_x | pre_y;
   wire dec_prefix = (op == ssx_pkg::OP_PREFIX_X) || (op == ssx_pkg::OP_PREFIX_Y);
   wire [1:0] pair_field = op[ssx_pkg::PAIR_FIELD_HI:ssx_pkg::PAIR_FIELD_LO];
   wire pop_form = ((op & ssx_pkg::POP_MASK) == ssx_pkg::POP_PATTERN);
   wire dec_pop = pop_form && (!op_prefixed || op == ssx_pkg::OP_POP_IDX);
   wire dec_xstack = (op == ssx_pkg::OP_SWAP_STACK);
   wire dec_swap_tp = (op == ssx_pkg::OP_SWAP_TGT_PTR) && !op_prefixed;
   wire dec_swap_acc = (op == ssx_pkg::OP_SWAP_ACC) && !op_prefixed;
   wire dec_bank = (op == ssx_pkg::OP_BANK_SWITCH) && !op_prefixed;
   wire [15:0] stack_ptr_plus1 = inc16(stack_pointer_o);
   wire [15:0] src_word = pre_x ? index_reg_x_o : (pre_y ? index_reg_y_o : pointer_pair_o);

   ssx_mcycle_timer u_timer
   (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .start_i(t_start),
      .len_i(t_len),
      .last_o(t_last)
   );

   always_comb
   begin
      next_state = state;
      t_start = 1'b0;
      t_len = ssx_pkg::T_FETCH;
      next_rd = 1'b0;
      next_wr = 1'b0;
      next_addr = mem_addr_o;
      next_wdata = mem_wdata_o;
      next_stack_ptr = stack_pointer_o;
      next_done = 1'b0;
      next_illegal = 1'b0;
      wr_en = 1'b0;
      wr_val = {mem_rdata_i, tmp_lo};
      wr_code = pair_field;
      swap_tp = 1'b0;
      swap_acc = 1'b0;
      swap_bank = 1'b0;
      ld_lo = 1'b0;
      ld_hi = 1'b0;
      case (state)
         ssx_pkg::ST_IDLE:
         begin
            if (fetch_valid_i)
            begin
               next_state = ssx_pkg::ST_FETCH;
               t_start = 1'b1;
            end
         end
         ssx_pkg::ST_FETCH:
         begin
            if (t_last)
            begin
               if (dec_prefix)
                  next_state = ssx_pkg::ST_IDLE;
               else if (dec_pop || dec_xstack)
               begin
                  next_state = ssx_pkg::ST_RD_LO;
                  t_start = 1'b1;
                  t_len = dec_pop ? ssx_pkg::T_POP_RD : ssx_pkg::T_XCHG_RD_LO;
                  next_rd = 1'b1;
                  next_addr = stack_pointer_o;
               end
               else
               begin
                  next_state = ssx_pkg::ST_IDLE;
                  swap_tp = dec_swap_tp;
                  swap_acc = dec_swap_acc;
                  swap_bank = dec_bank;
                  next_done = dec_swap_tp || dec_swap_acc || dec_bank;
                  next_illegal = !(dec_swap_tp || dec_swap_acc || dec_bank);
               end
            end
         end
         ssx_pkg::ST_RD_LO:
         begin
            next_rd = 1'b1;
            if (t_last)
            begin
               ld_lo = 1'b1;
               next_state = ssx_pkg::ST_RD_HI;
               t_start = 1'b1;
               next_addr = stack_ptr_plus1;
               if (dec_pop)
               begin
                  t_len = ssx_pkg::T_POP_RD;
                  next_stack_ptr = stack_ptr_plus1;
               end
               else
                  t_len = ssx_pkg::T_XCHG_RD_HI;
            end
         end
         ssx_pkg::ST_RD_HI:
         begin
            next_rd = 1'b1;
            if (t_last)
            begin
               if (dec_pop)
               begin
                  wr_en = 1'b1;
                  next_stack_ptr = stack_ptr_plus1;
                  next_state = ssx_pkg::ST_IDLE;
                  next_rd = 1'b0;
                  next_done = 1'b1;
               end
               else
               begin
                  ld_hi = 1'b1;
                  next_state = ssx_pkg::ST_WR_HI;
                  t_start = 1'b1;
                  t_len = ssx_pkg::T_XCHG_WR_HI;
                  next_rd = 1'b0;
                  next_wr = 1'b1;
                  next_wdata = src_word[15:8];
               end
            end
         end
         ssx_pkg::ST_WR_HI:
         begin
            next_wr = 1'b1;
            if (t_last)
            begin
               next_state = ssx_pkg::ST_WR_LO;
               t_start = 1'b1;
               t_len = ssx_pkg::T_XCHG_WR_LO;
               next_addr = stack_pointer_o;
               next_wdata = src_word[7:0];
            end
         end
         ssx_pkg::ST_WR_LO:
         begin
            next_wr = 1'b1;
            if (t_last)
            begin
               // Stack pointer never moves on this path
               wr_en = 1'b1;
               wr_val = {tmp_hi, tmp_lo};
               wr_code = ssx_pkg::PAIR_POINTER;
               next_state = ssx_pkg::ST_IDLE;
               next_wr = 1'b0;
               next_done = 1'b1;
            end
         end
         default:
            next_state = ssx_pkg::ST_IDLE;
      endcase
   end

   // Sequencer, opcode and prefix latch
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         state <= ssx_pkg::ST_IDLE;
         op <= ssx_pkg::BYTE_RESET;
         pre_x <= 1'b0;
         pre_y <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (state == ssx_pkg::ST_IDLE && fetch_valid_i)
            op <= fetch_byte_i;
         if (state == ssx_pkg::ST_FETCH && t_last && dec_prefix)
         begin
            // Later prefix overrides an earlier one
            pre_x <= (op == ssx_pkg::OP_PREFIX_X);
            pre_y <= (op == ssx_pkg::OP_PREFIX_Y);
         end
         else if (next_done || next_illegal)
         begin
            pre_x <= 1'b0;
            pre_y <= 1'b0;
         end
      end
   end

   // Memory strobes and handshake outputs
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         fetch_ready_o <= 1'b1;
         mem_rd_o <= 1'b0;
         mem_wr_o <= 1'b0;
         mem_addr_o <= ssx_pkg::REG_RESET;
         mem_wdata_o <= ssx_pkg::BYTE_RESET;
         done_o <= 1'b0;
         illegal_o <= 1'b0;
         tmp_lo <= ssx_pkg::BYTE_RESET;
         tmp_hi <= ssx_pkg::BYTE_RESET;
      end
      else
      begin
         fetch_ready_o <= (next_state == ssx_pkg::ST_IDLE);
         mem_rd_o <= next_rd;
         mem_wr_o <= next_wr;
         mem_addr_o <= next_addr;
         mem_wdata_o <= next_wdata;
         done_o <= next_done;
         illegal_o <= next_illegal;
         if (ld_lo)
            tmp_lo <= mem_rdata_i;
         if (ld_hi)
            tmp_hi <= mem_rdata_i;
      end
   end

   // Register file
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         counter_pair_o <= ssx_pkg::REG_RESET;
         target_pair_o <= ssx_pkg::REG_RESET;
         pointer_pair_o <= ssx_pkg::REG_RESET;
         accum_flag_pair_o <= ssx_pkg::REG_RESET;
         alt_counter_pair_o <= ssx_pkg::REG_RESET;
         alt_target_pair_o <= ssx_pkg::REG_RESET;
         alt_pointer_pair_o <= ssx_pkg::REG_RESET;
         alternate_accum_flag_pair_o <= ssx_pkg::REG_RESET;
         index_reg_x_o <= ssx_pkg::REG_RESET;
         index_reg_y_o <= ssx_pkg::REG_RESET;
         stack_pointer_o <= ssx_pkg::REG_RESET;
      end
      else
      begin
         stack_pointer_o <= next_stack_ptr;
         if (swap_tp)
         begin
            target_pair_o <= pointer_pair_o;
            pointer_pair_o <= target_pair_o;
         end
         if (swap_acc)
         begin
            accum_flag_pair_o <= alternate_accum_flag_pair_o;
            alternate_accum_flag_pair_o <= accum_flag_pair_o;
         end
         if (swap_bank)
         begin
            counter_pair_o <= alt_counter_pair_o;
            alt_counter_pair_o <= counter_pair_o;
            target_pair_o <= alt_target_pair_o;
            alt_target_pair_o <= target_pair_o;
            pointer_pair_o <= alt_pointer_pair_o;
            alt_pointer_pair_o <= pointer_pair_o;
         end
         if (wr_en)
         begin
            if (pre_x)
               index_reg_x_o <= wr_val;
            else if (pre_y)
               index_reg_y_o <= wr_val;
            else
            begin
               case (wr_code)
                  ssx_pkg::PAIR_COUNTER: counter_pair_o <= wr_val;
                  ssx_pkg::PAIR_TARGET: target_pair_o <= wr_val;
                  ssx_pkg::PAIR_POINTER: pointer_pair_o <= wr_val;
                  ssx_pkg::PAIR_ACCUM: accum_flag_pair_o <= wr_val;
                  default: accum_flag_pair_o <= accum_flag_pair_o;
               endcase
            end
         end
      end
   end
endmodule

// ==== ssx_mem_model.sv ====
// Stack memory model facing the pop/exchange executor
`timescale 1ns/1ps
module ssx_mem_model
(
   // Clock
   input wire logic clk_sys_i,
   // Memory port
   input wire logic mem_rd_i,
   input wire logic mem_wr_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o
);
   logic [7:0] mem [0:255];
   // Only 256 bytes, upper address bits alias
   // Inverted data when not read, so stale bytes never match
   assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i[7:0]] : ~mem[mem_addr_i[7:0]];
   initial
      for (int a = 0; a < 256; a++)
         mem[a] = 8'(a * 37 + 19);
   always @(posedge clk_sys_i)
      if (mem_wr_i)
         mem[mem_addr_i[7:0]] <= mem_wdata_i;
endmodule

// ==== ssx_exec_assertions.sv ====
// Concurrent checks on the pop/exchange executor ports
`timescale 1ns/1ps
module ssx_exec_assertions
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Fetch and memory
   input wire logic fetch_valid_i,
   input wire logic [7:0] fetch_byte_i,
   input wire logic fetch_ready_o,
   input wire logic mem_rd_o,
   input wire logic mem_wr_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic done_o,
   // Registers
   input wire logic [15:0] target_pair_o,
   input wire logic [15:0] pointer_pair_o,
   input wire logic [15:0] accum_flag_pair_o,
   input wire logic [15:0] alternate_accum_flag_pair_o,
   input wire logic [15:0] stack_pointer_o
);
   logic pfx;
   // Unprefixed byte taken; a prefixed one may legally be refused
   wire take = fetch_valid_i && fetch_ready_o && !pfx;
   always_ff @(posedge clk_sys_i)
      if (rst_i)
         pfx <= 1'b0;
      else if (fetch_valid_i && fetch_ready_o)
         pfx <= fetch_byte_i == ssx_pkg::OP_PREFIX_X || fetch_byte_i == ssx_pkg::OP_PREFIX_Y;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_rd_top_addr: assert property ($rose(mem_rd_o) |-> mem_addr_o == stack_pointer_o)
      else $error("first stack read not at stack pointer");
   a_rd_hi_addr: assert property (
      $rose(mem_rd_o) |-> ##3 mem_addr_o == 16'($past(mem_addr_o, 3) + 16'h1))
      else $error("high byte not read one above low byte");
   a_rd_len: assert property ($rose(mem_rd_o) |-> mem_rd_o [*6])
      else $error("read cycles shorter than six clocks");
   a_pop_done: assert property ($rose(mem_rd_o) ##6 !mem_rd_o |-> done_o)
      else $error("pop not done after its two reads");
   a_xchg_phase: assert property (
      $rose(mem_rd_o) ##6 mem_rd_o |=> mem_wr_o && !mem_rd_o)
      else $error("exchange write not after seven read clocks");
   a_wr_len: assert property ($rose(mem_wr_o) |-> mem_wr_o [*8] ##1 !mem_wr_o)
      else $error("exchange writes not eight clocks");
   a_wr_order: assert property (
      $rose(mem_wr_o) |-> mem_addr_o == 16'(stack_pointer_o + 16'h1) ##3
      mem_addr_o == stack_pointer_o)
      else $error("exchange write addresses wrong");
   a_stack_step: assert property (
      $changed(stack_pointer_o) |-> stack_pointer_o == 16'($past(stack_pointer_o) + 16'h1))
      else $error("stack pointer moved by other than one");
   a_stack_hold: assert property (mem_wr_o |-> $stable(stack_pointer_o))
      else $error("stack pointer moved during exchange");
   // Byte taken at one edge, done_o launched four edges later, seen one edge after that
   a_swap_tp: assert property (take && fetch_byte_i == ssx_pkg::OP_SWAP_TGT_PTR |-> ##5
      done_o && target_pair_o == $past(pointer_pair_o, 5) &&
      pointer_pair_o == $past(target_pair_o, 5))
      else $error("target and pointer swap wrong");
   a_swap_acc: assert property (take && fetch_byte_i == ssx_pkg::OP_SWAP_ACC |-> ##5
      done_o && accum_flag_pair_o == $past(alternate_accum_flag_pair_o, 5))
      else $error("accumulator swap wrong");
   a_bank_done: assert property (
      take && fetch_byte_i == ssx_pkg::OP_BANK_SWITCH |-> ##5 done_o)
      else $error("bank switch not done after one machine cycle");
   a_xchg_done: assert property ($rose(mem_wr_o) |-> ##8 done_o)
      else $error("exchange not done after its two writes");
   c_pop: cover property ($rose(mem_rd_o) ##6 !mem_rd_o);
   c_xchg: cover property ($rose(mem_wr_o));
   c_bank: cover property (take && fetch_byte_i == ssx_pkg::OP_BANK_SWITCH ##5 done_o);
endmodule
bind ssx_exec ssx_exec_assertions i_ssx_exec_assertions (.*);

// ==== ssx_exec_tb_top.sv ====
// Self-checking bench for the stack pop and exchange executor
`timescale 1ns/1ps
module ssx_exec_tb_top;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic fetch_valid_i = 1'b0;
   logic [7:0] fetch_byte_i = 8'h00;
   logic fetch_ready_o, mem_rd_o, mem_wr_o, done_o, illegal_o;
   logic [7:0] mem_rdata_i, mem_wdata_o;
   logic [15:0] mem_addr_o, stack_pointer_o;
   wire logic [15:0] rf [0:9];
   logic [15:0] exp_stack_ptr = 16'h0000;
   int err_count = 0;
   int cmp_count = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   ssx_exec i_ssx_exec (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .fetch_valid_i(fetch_valid_i),
      .fetch_byte_i(fetch_byte_i), .fetch_ready_o(fetch_ready_o), .mem_rdata_i(mem_rdata_i),
      .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o), .done_o(done_o), .illegal_o(illegal_o),
      .counter_pair_o(rf[0]), .target_pair_o(rf[1]), .pointer_pair_o(rf[2]),
      .accum_flag_pair_o(rf[3]), .alt_counter_pair_o(rf[4]), .alt_target_pair_o(rf[5]),
      .alt_pointer_pair_o(rf[6]), .alternate_accum_flag_pair_o(rf[7]),
      .index_reg_x_o(rf[8]), .index_reg_y_o(rf[9]), .stack_pointer_o(stack_pointer_o));
   ssx_mem_model i_ssx_mem_model (.clk_sys_i(clk_sys_i), .mem_rd_i(mem_rd_o),
      .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
      .mem_rdata_o(mem_rdata_i));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [15:0] top2(input logic [15:0] a);
      return {i_ssx_mem_model.mem[8'(a + 16'h1)], i_ssx_mem_model.mem[a[7:0]]};
   endfunction
   // Entered just after an edge; returns just after the taking edge
   task automatic send(input logic [7:0] b);
      for (int w = 0; w < 50 && fetch_ready_o !== 1'b1; w++)
         @(posedge clk_sys_i) #1;
      fetch_valid_i = 1'b1;
      fetch_byte_i = b;
      @(posedge clk_sys_i) #1;
      fetch_valid_i = 1'b0;
   endtask
   // Prefix timed to ready, opcode timed from take to done
   task automatic op(input logic [7:0] pre, input logic [7:0] opc, input logic [15:0] lat);
      int n;
      n = 0;
      if (pre != 8'h00)
      begin
         send(pre);
         while (fetch_ready_o !== 1'b1 && n < 40)
         begin
            @(posedge clk_sys_i) #1;
            n++;
         end
         chk("prefix clocks", 16'(n), 16'd4);
         n = 0;
      end
      send(opc);
      while (done_o !== 1'b1 && n < 40)
      begin
         @(posedge clk_sys_i) #1;
         n++;
      end
      chk("clocks", 16'(n), lat);
   endtask
   task automatic t_pop(input logic [7:0] pre, input logic [7:0] opc, input int k);
      logic [15:0] e;
      e = top2(exp_stack_ptr);
      op(pre, opc, 16'd10);
      exp_stack_ptr = exp_stack_ptr + 16'h2;
      chk("pop value", rf[k], e);
      chk("pop stack pointer", stack_pointer_o, exp_stack_ptr);
   endtask
   task automatic t_xstk(input logic [7:0] pre, input int k);
      logic [15:0] r;
      logic [15:0] m;
      r = rf[k];
      m = top2(exp_stack_ptr);
      op(pre, ssx_pkg::OP_SWAP_STACK, 16'd19);
      chk("xchg reg", rf[k], m);
      chk("xchg mem", top2(exp_stack_ptr), r);
      chk("xchg stack pointer", stack_pointer_o, exp_stack_ptr);
   endtask
   // Pairs a..a+m-1 trade places with b..b+m-1, all else must hold
   task automatic t_swap(input logic [7:0] opc, input int a, input int b, input int m);
      logic [15:0] s [0:9];
      for (int k = 0; k < 10; k++)
         s[k] = rf[k];
      op(8'h00, opc, 16'd4);
      for (int k = 0; k < 10; k++)
         chk("swap", rf[k], (k >= a && k < a + m) ? s[k + b - a] :
            (k >= b && k < b + m) ? s[k - b + a] : s[k]);
   endtask
   task automatic t_illegal(input logic [7:0] pre, input logic [7:0] opc);
      logic [15:0] s [0:9];
      int n;
      n = 0;
      for (int k = 0; k < 10; k++)
         s[k] = rf[k];
      if (pre != 8'h00)
         send(pre);
      send(opc);
      while (illegal_o !== 1'b1 && n < 40)
      begin
         @(posedge clk_sys_i) #1;
         n++;
      end
      chk("illegal", {15'h0, illegal_o}, 16'h0001);
      for (int k = 0; k < 10; k++)
         chk("illegal keep", rf[k], s[k]);
      chk("illegal stack pointer", stack_pointer_o, exp_stack_ptr);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk_sys_i);
      #1;
      rst_i = 1'b0;
      for (int k = 0; k < 10; k++)
         chk("reg reset", rf[k], 16'h0000);
      chk("stack pointer reset", stack_pointer_o, 16'h0000);
      for (int q = 0; q < 4; q++)
         t_pop(8'h00, {2'b11, 2'(q), 4'h1}, q);
      t_pop(ssx_pkg::OP_PREFIX_X, ssx_pkg::OP_POP_IDX, 8);
      t_pop(ssx_pkg::OP_PREFIX_Y, ssx_pkg::OP_POP_IDX, 9);
      // Second prefix must override the first
      send(ssx_pkg::OP_PREFIX_X);
      t_pop(ssx_pkg::OP_PREFIX_Y, ssx_pkg::OP_POP_IDX, 9);
      t_xstk(8'h00, 2);
      t_xstk(ssx_pkg::OP_PREFIX_X, 8);
      t_xstk(ssx_pkg::OP_PREFIX_Y, 9);
      t_swap(ssx_pkg::OP_SWAP_TGT_PTR, 1, 2, 1);
      t_swap(ssx_pkg::OP_SWAP_ACC, 3, 7, 1);
      t_swap(ssx_pkg::OP_BANK_SWITCH, 0, 4, 3);
      t_swap(ssx_pkg::OP_BANK_SWITCH, 0, 4, 3);
      t_illegal(ssx_pkg::OP_PREFIX_X, ssx_pkg::OP_SWAP_TGT_PTR);
      t_illegal(ssx_pkg::OP_PREFIX_Y, 8'hc1);
      t_illegal(8'h00, 8'h00);
      // Prefix must be gone after the discard
      t_swap(ssx_pkg::OP_SWAP_TGT_PTR, 1, 2, 1);
      results;
   end
   initial
   begin
      #20000;
      err_count++;
      results;
   end
endmodule
